// >>> smrs_pkg.sv
// package for the stop mode release sequencer: register map, field positions,
// reset values and timing constants. assumes an APB slave with 32-bit data.
package smrs_pkg;
  // register byte offsets
  localparam logic [11:0] OFF_PROT_CMD   = 12'h000; // protection_command
  localparam logic [11:0] OFF_PWR_SAVE   = 12'h004; // power_save_control
  localparam logic [11:0] OFF_SETTLE_SEL = 12'h008; // osc_settle_select
  localparam logic [11:0] OFF_STATUS     = 12'h00C; // state and flags
  localparam logic [11:0] OFF_STAT_WORD  = 12'h010; // program_status_word flags
  localparam logic [11:0] OFF_IRQ_MASK  = 12'h014; // maskable request mask
  localparam logic [11:0] OFF_EXT6_CFG  = 12'h018; // ext_irq_six sampling select
  // power_save_control fields
  localparam int SAVE_STOP_BIT = 1;  // stop_request_bit
  localparam int SAVE_IDLE_BIT = 2;
  // program_status_word fields
  localparam int WORD_IDIS_BIT = 5;  // interrupt_disable_flag
  localparam int WORD_NMI_BIT  = 7;  // nmi_in_progress_flag
  // reset values
  localparam logic [2:0] SETTLE_SEL_RST = 3'h0;
  localparam logic [7:0] IRQ_MASK_RST = 8'hFF;
  localparam int         NUM_IRQ      = 8;
  // settling exponents: code 0 keeps the reset default, code n gives 2^(14+n)
  localparam logic [4:0] SETTLE_EXP_MIN = 5'h0E;
  localparam logic [4:0] SETTLE_EXP_BASE_RST = 5'h12; // 18
  localparam int         SETTLE_CNT_W = 22;
  // dummy instructions run between store and entry
  localparam logic [2:0] DUMMY_SLOTS = 3'h2;
  typedef enum logic [2:0] {SMRS_RUN, SMRS_DRAIN, SMRS_IDLE, SMRS_STOP,
                            SMRS_SETTLE} smrs_state_t;
endpackage

// >>> smrs_top.sv
// stop mode release sequencer: APB register file, protected power save entry,
// stop/idle hold, wake on interrupt, oscillator settling count.
// assumes clk is the main clock and wake pins are asynchronous to it.
//
// Summary of operation
// - setting stop_request_bit after a protected write halts main clock, subclock kept.
// - a bus_hold_request is never acknowledged while stopped.
// - an NMI or an unmasked maskable request releases stop.
// - an interrupt release starts the dedicated settle counter as the settle timer.
// - the settle length is taken from osc_settle_select.
// - clock output and handler branch happen only after settling ends.
// - after reset the settle length is 2^18 main clocks by default (2^21 variant).
// - ext_irq_six detects edges in stop only when sampled on the subclock.
// - the instructions after the store run before the mode is entered.
// - after release a request stays pending while either status word flag is set.
`timescale 1ns/100ps
`default_nettype none
module smrs_top #(
  parameter logic [4:0] SETTLE_EXP_RST = smrs_pkg::SETTLE_EXP_BASE_RST
) (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        srst,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic             pready,
  output logic [31:0]      prdata,
  output logic             pslverr,
  // wake sources and bus hold request, asynchronous
  input  wire logic        nmi_in,
  input  wire logic [7:0]  irq_in,
  input  wire logic        ext_irq_six,
  input  wire logic        bus_hold_request,
  // cpu side
  input  wire logic        dummy_done,
  output logic             main_clk_en,
  output logic             sub_clk_en,
  output logic             cpu_clk_en,
  output logic             bus_hold_ack,
  output logic             vector_req,
  output logic [3:0]       vector_id
);
  // two-stage synchronisers for all asynchronous pins
  // the first stage may go metastable, so only the second stage feeds logic;
  // this costs two cycles of wake latency, which the settle count dwarfs
  logic [10:0] sync1_r;
  logic [10:0] sync2_r;
  always_ff @(posedge clk) begin
    if (srst) begin
      sync1_r <= 11'h000;
      sync2_r <= 11'h000;
    end else begin
      sync1_r <= {bus_hold_request, ext_irq_six, irq_in, nmi_in};
      sync2_r <= sync1_r;
    end
  end
  wire logic       nmi_s  = sync2_r[0];
  wire logic [7:0] irq_s  = sync2_r[8:1];
  wire logic       ext6_s = sync2_r[9];
  wire logic       hold_s = sync2_r[10];

  // settle counter width, declared first so the state below can use it
  localparam int SETTLE_CNT_W_L = smrs_pkg::SETTLE_CNT_W;

  // sequencer state and software visible configuration
  smrs_pkg::smrs_state_t state_r;
  logic        prot_armed_r;
  logic [2:0]  settle_sel_r;
  logic [7:0]  mask_r;
  logic        ext6_sub_r;
  // status word flags that hold a released request pending
  logic        nmi_busy_r;
  logic        irq_dis_r;
  // pending power save request and drain bookkeeping
  logic        stop_req_r;
  logic        idle_req_r;
  logic [2:0]  dummy_cnt_r;
  logic [SETTLE_CNT_W_L-1:0] settle_r;
  logic        ext6_prev_r;
  logic [3:0]  wake_src_r;

  wire logic wr_acc = psel && penable && pwrite;
  wire logic rd_acc = psel && penable && !pwrite;
  wire logic mapped = (paddr <= smrs_pkg::OFF_EXT6_CFG) && (paddr[1:0] == 2'b00);

  // ext_irq_six edge only counts in stop when sampled on the subclock
  wire logic ext6_edge = ext6_s && !ext6_prev_r;
  wire logic ext6_live = ext6_edge && (state_r != smrs_pkg::SMRS_STOP || ext6_sub_r);
  wire logic [7:0] unmasked = (irq_s | {ext6_live, 7'h00}) & ~mask_r;
  wire logic wake = nmi_s || (|unmasked);

  // priority encoder for handler id: nmi first, then lowest request
  logic [3:0] src_nxt;
  always_comb begin
    src_nxt = 4'hF;
    for (int i = smrs_pkg::NUM_IRQ - 1; i >= 0; i--) begin
      if (unmasked[i]) src_nxt = i[3:0];
    end
    if (nmi_s) src_nxt = 4'h8;
  end

  // settle count length, 2^(exp) clocks; from select, reset default
  // code 0 keeps the reset default, so a part that was never configured
  // still waits the long, safe interval; codes above step from the minimum
  wire logic [4:0] settle_exp = (settle_sel_r == 3'h0) ? SETTLE_EXP_RST
                              : 5'(smrs_pkg::SETTLE_EXP_MIN + 5'(settle_sel_r));
  wire logic [SETTLE_CNT_W_L-1:0] settle_len =
    SETTLE_CNT_W_L'(({{(SETTLE_CNT_W_L-1){1'b0}}, 1'b1} << settle_exp) - 1'b1);

  // protection arm: set by a protection_command write, cleared by any other write
  always_ff @(posedge clk) begin
    if (srst) prot_armed_r <= 1'b0;
    else if (wr_acc) prot_armed_r <= (paddr == smrs_pkg::OFF_PROT_CMD);
  end

  // configuration registers
  // all requests start masked so that a stop entered straight after reset
  // can only be left by the nmi or by reset itself;
  // the select may change while stopped but is only used at the wake edge
  always_ff @(posedge clk) begin
    if (srst) begin
      settle_sel_r <= smrs_pkg::SETTLE_SEL_RST;
      mask_r       <= smrs_pkg::IRQ_MASK_RST;
      ext6_sub_r   <= 1'b0;
    end else if (wr_acc) begin
      if (paddr == smrs_pkg::OFF_SETTLE_SEL) settle_sel_r <= pwdata[2:0];
      if (paddr == smrs_pkg::OFF_IRQ_MASK) mask_r <= pwdata[7:0];
      if (paddr == smrs_pkg::OFF_EXT6_CFG) ext6_sub_r <= pwdata[0];
    end
  end

  // program status word flags, software owned
  // only the two flags that gate a pending vector are kept here; the rest
  // of the word lives in the cpu and reads back as zero
  always_ff @(posedge clk) begin
    if (srst) begin
      nmi_busy_r <= 1'b0;
      irq_dis_r  <= 1'b0;
    end else if (wr_acc && paddr == smrs_pkg::OFF_STAT_WORD) begin
      nmi_busy_r <= pwdata[smrs_pkg::WORD_NMI_BIT];
      irq_dis_r  <= pwdata[smrs_pkg::WORD_IDIS_BIT];
    end
  end

  // main sequencer
  always_ff @(posedge clk) begin
    if (srst) begin
      state_r     <= smrs_pkg::SMRS_RUN;
      stop_req_r  <= 1'b0;
      idle_req_r  <= 1'b0;
      dummy_cnt_r <= 3'h0;
      settle_r    <= '0;
      wake_src_r  <= 4'h0;
    end else begin
      unique case (state_r)
        smrs_pkg::SMRS_RUN: begin
          // protected store only
          // the arm flag is the value before this write, so a second store
          // without a fresh command finds it cleared and is ignored;
          // stop wins when both mode bits are written at once
          if (wr_acc && paddr == smrs_pkg::OFF_PWR_SAVE && prot_armed_r &&
              (pwdata[smrs_pkg::SAVE_STOP_BIT] || pwdata[smrs_pkg::SAVE_IDLE_BIT])) begin
            stop_req_r  <= pwdata[smrs_pkg::SAVE_STOP_BIT];
            idle_req_r  <= !pwdata[smrs_pkg::SAVE_STOP_BIT];
            dummy_cnt_r <= smrs_pkg::DUMMY_SLOTS;
            state_r     <= smrs_pkg::SMRS_DRAIN;
          end
        end
        smrs_pkg::SMRS_DRAIN: begin
          if (dummy_done || dummy_cnt_r == 3'h0) begin
            state_r <= stop_req_r ? smrs_pkg::SMRS_STOP : smrs_pkg::SMRS_IDLE;
          end else begin
            dummy_cnt_r <= dummy_cnt_r - 3'h1;
          end
        end
        smrs_pkg::SMRS_IDLE: begin
          if (wake) begin
            wake_src_r <= src_nxt;
            idle_req_r <= 1'b0;
            state_r    <= smrs_pkg::SMRS_RUN;
          end
        end
        smrs_pkg::SMRS_STOP: begin
          if (wake) begin
            wake_src_r <= src_nxt;
            settle_r   <= settle_len;
            state_r    <= smrs_pkg::SMRS_SETTLE;
          end
        end
        smrs_pkg::SMRS_SETTLE: begin
          if (settle_r == '0) begin
            stop_req_r <= 1'b0;
            state_r   <= smrs_pkg::SMRS_RUN;
          end else begin
            settle_r <= settle_r - 1'b1;
          end
        end
      endcase
    end
  end

  // edge history for ext_irq_six
  always_ff @(posedge clk) begin
    if (srst) ext6_prev_r <= 1'b0;
    else ext6_prev_r <= ext6_s;
  end

  // pending vector: set at release, held while np or id is set
  logic pend_r;
  always_ff @(posedge clk) begin
    if (srst) begin
      pend_r     <= 1'b0;
      vector_req <= 1'b0;
      vector_id  <= 4'h0;
    end else begin
      vector_req <= 1'b0;
      if ((state_r == smrs_pkg::SMRS_SETTLE && settle_r == '0) ||
          (state_r == smrs_pkg::SMRS_IDLE && wake)) begin
        pend_r <= 1'b1;
      // hold while masked by flags
      // a held vector leaves one cycle after software clears both flags;
      // the source stays latched so a later request cannot overwrite it
      // unless a new release happens first
      end else if (pend_r && !nmi_busy_r && !irq_dis_r) begin
        pend_r     <= 1'b0;
        vector_req <= 1'b1;
        vector_id  <= wake_src_r;
      end
    end
  end

  // clock enables and hold acknowledge
  always_ff @(posedge clk) begin
    if (srst) begin
      main_clk_en  <= 1'b1;
      sub_clk_en   <= 1'b1;
      cpu_clk_en   <= 1'b1;
      bus_hold_ack <= 1'b0;
    end else begin
      // main oscillator off in stop
      // dropped in the same cycle as the cpu clock, never earlier, so the cpu
      // is never clocked while the main oscillator is off
      main_clk_en  <= (state_r != smrs_pkg::SMRS_STOP);
      sub_clk_en   <= 1'b1;
      cpu_clk_en   <= (state_r == smrs_pkg::SMRS_RUN || state_r == smrs_pkg::SMRS_DRAIN);
      bus_hold_ack <= hold_s && state_r != smrs_pkg::SMRS_STOP &&
                      state_r != smrs_pkg::SMRS_SETTLE;
    end
  end

  // apb read data, zero wait states
  always_ff @(posedge clk) begin
    if (srst) begin
      pready  <= 1'b0;
      prdata  <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else begin
      pready  <= psel && !penable;
      pslverr <= psel && !penable && !mapped;
      prdata  <= 32'h0000_0000;
      if (psel && !penable && !pwrite) begin
        unique case (paddr)
          // read data is prepared in the setup cycle so that it already
          // stands at the access edge; the protection command reads as zero
          smrs_pkg::OFF_PWR_SAVE:   prdata <= {29'h0, idle_req_r, stop_req_r, 1'b0};
          smrs_pkg::OFF_SETTLE_SEL: prdata <= {29'h0, settle_sel_r};
          smrs_pkg::OFF_STATUS:     prdata <= {23'h0, pend_r, wake_src_r, 1'b0, 3'(state_r)};
          smrs_pkg::OFF_STAT_WORD:  prdata <= {24'h0, nmi_busy_r, 1'b0, irq_dis_r, 5'h00};
          smrs_pkg::OFF_IRQ_MASK: prdata <= {24'h0, mask_r};
          smrs_pkg::OFF_EXT6_CFG: prdata <= {31'h0, ext6_sub_r};
          default:                prdata <= 32'h0000_0000;
        endcase
      end
    end
  end
  // reads have no side effects, so the read strobe is kept only for clarity
  wire logic unused_rd = rd_acc;
endmodule
`default_nettype wire

// >>> smrs_top_assertions.sv
// checker on the top ports of the stop mode release sequencer
// assumes one clock domain, srst synchronous, settle exponent of 3
`timescale 1ns/100ps
`default_nettype none
module smrs_assertions #(
  parameter logic [4:0] SETTLE_EXP_RST = 5'h03
) (
  // clock, reset and bus
  input wire logic        clk,
  input wire logic        srst,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic        pready,
  // wake and clock control
  input wire logic        nmi_in,
  input wire logic        main_clk_en,
  input wire logic        sub_clk_en,
  input wire logic        cpu_clk_en,
  input wire logic        bus_hold_ack,
  input wire logic        vector_req
);
  logic wr_ok;
  logic prot_r;
  default clocking @(posedge clk); endclocking
  default disable iff (srst);
  // a write completes only at the access edge
  assign wr_ok = psel && penable && pready && pwrite;
  // any other write between the two closes the protection window
  always_ff @(posedge clk) begin
    if (srst) prot_r <= 1'b0;
    else if (wr_ok) prot_r <= (paddr == smrs_pkg::OFF_PROT_CMD);
  end
  sequence prot_save_s;
    wr_ok && paddr == smrs_pkg::OFF_PWR_SAVE && prot_r && pwdata[smrs_pkg::SAVE_STOP_BIT];
  endsequence
  sequence bare_save_s; wr_ok && paddr == smrs_pkg::OFF_PWR_SAVE && !prot_r; endsequence
  sequence drain_s; cpu_clk_en ##[1:6] !main_clk_en; endsequence
  apb_ready_a: assert property (psel && penable |-> pready)
    else $error("no ready in access phase");
  ready_only_a: assert property (pready |-> psel && penable)
    else $error("ready outside access phase");
  sub_clk_a: assert property (sub_clk_en)
    else $error("subclock stopped");
  stop_cpu_a: assert property (!main_clk_en |-> !cpu_clk_en)
    else $error("cpu clock without main clock");
  hold_ack_a: assert property (!main_clk_en |-> !bus_hold_ack)
    else $error("hold acknowledged in stop");
  drain_stop_a: assert property (prot_save_s |=> drain_s)
    else $error("stop entry order wrong");
  bad_save_a: assert property (bare_save_s |=> main_clk_en [*8])
    else $error("unprotected write entered stop");
  nmi_wake_a: assert property (!main_clk_en && nmi_in |-> ##[1:5] main_clk_en)
    else $error("nmi did not release stop");
  settle_a: assert property ($rose(main_clk_en) |-> !cpu_clk_en [*7])
    else $error("cpu clock before settling");
  vec_run_a: assert property (vector_req |-> cpu_clk_en ##1 !vector_req)
    else $error("vector outside run");
endmodule
bind smrs_top smrs_assertions #(.SETTLE_EXP_RST(SETTLE_EXP_RST)) i_smrs_assertions (
  .clk(clk), .srst(srst), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .pwdata(pwdata), .pready(pready), .nmi_in(nmi_in), .main_clk_en(main_clk_en),
  .sub_clk_en(sub_clk_en), .cpu_clk_en(cpu_clk_en), .bus_hold_ack(bus_hold_ack),
  .vector_req(vector_req));
`default_nettype wire

// >>> smrs_top_test.sv
// self-checking bench for the stop mode release sequencer
// assumes a 100 MHz clock and a settle exponent of 3 after reset
`timescale 1ns/100ps
`default_nettype none
module smrs_top_test;
  logic        clk, srst, psel, penable, pwrite, pready, pslverr, er, nmi_in;
  logic        bus_hold_request, main_clk_en, sub_clk_en, cpu_clk_en, bus_hold_ack;
  logic        vector_req;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [7:0]  irq_in;
  logic [3:0]  vector_id;
  logic [2:0]  mon;
  int          err_total, checked, n, mb;
  logic        ext6, dd;
  int          exp_q[$];
  assign mon = {vector_req, cpu_clk_en, main_clk_en};
  smrs_top #(.SETTLE_EXP_RST(5'h03)) i_smrs_top (.clk(clk), .srst(srst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
    .prdata(prdata), .pslverr(pslverr), .nmi_in(nmi_in), .irq_in(irq_in),
    .ext_irq_six(ext6), .bus_hold_request(bus_hold_request), .dummy_done(dd),
    .main_clk_en(main_clk_en), .sub_clk_en(sub_clk_en), .cpu_clk_en(cpu_clk_en),
    .bus_hold_ack(bus_hold_ack), .vector_req(vector_req), .vector_id(vector_id));
  // free-running main clock
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  task automatic end_sim;
    if (err_total == 0 && checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic chk(input logic [31:0] s, input logic [31:0] e, input string nm);
    checked++;
    if (s !== e) begin
      err_total++;
      $display("wrong value %s expected %h seen %h", nm, e, s);
    end
  endtask
  // one apb transfer, held until ready is sampled high
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int k;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge clk);
      k++;
      if (k > 50) begin
        err_total++;
        end_sim;
      end
    end while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // bounded wait for bit b of the monitor to reach v, n counts edges
  task automatic wt(input int b, input logic v);
    n = 0;
    while (mon[b] !== v) begin
      @(posedge clk);
      n++;
      if (n > 40000) begin
        err_total++;
        end_sim;
      end
    end
  endtask
  // full stop, wake and vector round; src 8 stands for the nmi,
  // x6 selects subclock sampling and wakes through ext_irq_six (src 7)
  task automatic sc(input int os, input logic [31:0] program_status_word, input int src, input logic x6);
    int e;
    e = (os == 0) ? 8 : 2 ** (int'(smrs_pkg::SETTLE_EXP_MIN) + os);
    mb = (src + 1 + $urandom % 6) % 7;
    apb(1'b1, smrs_pkg::OFF_SETTLE_SEL, 32'(os));
    apb(1'b1, smrs_pkg::OFF_EXT6_CFG, 32'(x6));
    apb(1'b1, smrs_pkg::OFF_IRQ_MASK, ~((32'h1 << src) | 32'h80));
    apb(1'b1, smrs_pkg::OFF_STAT_WORD, program_status_word);
    apb(1'b1, smrs_pkg::OFF_PROT_CMD, $urandom % 256);
    apb(1'b1, smrs_pkg::OFF_PWR_SAVE, 32'h2);
    // dummy_done is pulsed at random, so the drain ends on it or on the dummy window
    dd <= 1'($urandom % 2);
    @(posedge clk);
    dd <= 1'b0;
    wt(0, 1'b0);
    chk(32'(cpu_clk_en), 32'h0, "cpu_clk_en");
    bus_hold_request <= 1'b1;
    irq_in[mb] <= 1'b1;
    ext6 <= !x6;
    repeat (20) @(posedge clk);
    chk(32'(mon), 32'h0, "stopped");
    chk(32'(main_clk_en), 32'h0, "ext6 gated");
    chk(32'(bus_hold_ack), 32'h0, "bus_hold_ack");
    if (src == 8) nmi_in <= 1'b1;
    else if (x6) ext6 <= 1'b1;
    else irq_in[src] <= 1'b1;
    exp_q.push_back(src);
    wt(0, 1'b1);
    nmi_in <= 1'b0;
    irq_in <= 8'h00;
    ext6 <= 1'b0;
    bus_hold_request <= 1'b0;
    wt(1, 1'b1);
    chk(32'(n >= e && n <= e + 6), 32'h1, "settle");
    if (program_status_word != 0) begin
      repeat (20) begin
        @(posedge clk);
        chk(32'(vector_req), 32'h0, "held");
      end
      apb(1'b1, smrs_pkg::OFF_STAT_WORD, 32'h0);
    end
    wt(2, 1'b1);
    chk(32'(vector_id), 32'(exp_q.pop_front()), "vector_id");
  endtask
  // main sequence
  initial begin
    {srst, psel, penable, pwrite, nmi_in, bus_hold_request} = 6'h20;
    {paddr, pwdata, irq_in, ext6, dd} = '0;
    err_total = 0;
    checked = 0;
    void'($urandom(32'hB0CF));
    repeat (6) @(posedge clk);
    srst <= 1'b0;
    chk(32'({main_clk_en, sub_clk_en, cpu_clk_en, bus_hold_ack}), 32'hE, "reset");
    apb(1'b0, smrs_pkg::OFF_SETTLE_SEL, 32'h0);
    chk(rd, 32'(smrs_pkg::SETTLE_SEL_RST), "settle_sel");
    apb(1'b0, smrs_pkg::OFF_IRQ_MASK, 32'h0);
    chk(rd, 32'hFF, "mask");
    apb(1'b0, 12'h100, 32'h0);
    chk(32'(er), 32'h1, "pslverr");
    apb(1'b1, smrs_pkg::OFF_PROT_CMD, 32'h0);
    apb(1'b1, smrs_pkg::OFF_SETTLE_SEL, 32'h0);
    apb(1'b1, smrs_pkg::OFF_PWR_SAVE, 32'h2);
    apb(1'b1, smrs_pkg::OFF_PWR_SAVE, 32'h2);
    repeat (10) @(posedge clk);
    chk(32'(main_clk_en), 32'h1, "no entry");
    sc(0, 32'h0, $urandom % 8, 1'b0);
    sc(0, 32'h80, 8, 1'b0);
    sc(1, 32'h20, $urandom % 8, 1'b0);
    sc(0, 32'h0, 7, 1'b1);
    // idle keeps the main clock and wakes on the nmi
    apb(1'b1, smrs_pkg::OFF_PROT_CMD, 32'h0);
    apb(1'b1, smrs_pkg::OFF_PWR_SAVE, 32'h4);
    wt(1, 1'b0);
    chk(32'(main_clk_en), 32'h1, "idle main");
    nmi_in <= 1'b1;
    wt(2, 1'b1);
    nmi_in <= 1'b0;
    chk(32'(vector_id), 32'h8, "idle vector");
    end_sim;
  end
endmodule
`default_nettype wire
